// ===== logic/tm3_cfg.svh
`ifndef TM3_CFG_SVH
`define TM3_CFG_SVH

// register bus geometry
`define TM3_ADDR_W 3
`define TM3_DATA_W 8

// register indexes on the plain register port
`define TM3_IDX_CTRL 3'h0
`define TM3_IDX_CNT_LO 3'h1
`define TM3_IDX_CNT_HI 3'h2
`define TM3_IDX_RLD_LO 3'h3
`define TM3_IDX_RLD_HI 3'h4

// control field positions
`define TM3_BIT_HI_FLAG 7
`define TM3_BIT_LO_FLAG 6
`define TM3_BIT_LO_IE 5
`define TM3_BIT_CAP_EN 4
`define TM3_BIT_SPLIT 3
`define TM3_BIT_RUN 2

// reset values and constants
`define TM3_CTRL_RST 8'h00
`define TM3_BYTE_RST 8'h00
`define TM3_BYTE_MAX 8'hFF
`define TM3_BYTE_ONE 8'h01
`define TM3_RD_UNMAPPED 8'h00

`endif

// ===== logic/tm3_pkg.sv
`include "tm3_cfg.svh"

package tm3_pkg;

	typedef struct packed {
		logic high_byte_overflow_flag;
		logic low_byte_overflow_flag;
		logic low_byte_interrupt_enable;
		logic capture_mode_enable;
		logic split_mode_select;
		logic timer_run_control;
		logic [1:0] clock_select;
	} tm3_ctrl_t;

	typedef struct packed {
		logic [`TM3_ADDR_W-1:0] addr;
		logic [`TM3_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tm3_req_t;

endpackage : tm3_pkg

// ===== logic/tm3_byte.sv
`timescale 1ns/1ns
`include "tm3_cfg.svh"

module tm3_byte (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// software load
	input wire logic sw_load_i,
	input wire logic [7:0] sw_data_i,
	// counting
	input wire logic inc_i,
	input wire logic reload_i,
	input wire logic [7:0] reload_val_i,
	// state
	output logic [7:0] count_o,
	output logic roll_o
);

	logic [7:0] next_count;

	assign roll_o = inc_i & (count_o == `TM3_BYTE_MAX);

	// software write wins; a reload replaces the natural wrap to zero
	assign next_count = sw_load_i ? sw_data_i :
		(roll_o & reload_i) ? reload_val_i :
		inc_i ? 8'(count_o + `TM3_BYTE_ONE) : count_o;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_o <= `TM3_BYTE_RST;
		end else begin
			count_o <= next_count;
		end
	end

endmodule : tm3_byte

// ===== logic/tm3_ctrl.sv
// Operation
// R1: the low-byte flag sets on every low byte wrap from 0xFF to 0x00.
// R2: the low-byte flag stays set until software writes it to zero.
// R3: the low-byte enable makes a low-byte overflow an interrupt source.
// R4: a low overflow interrupts only with low and general enables both set.
// R5: with capture enable set, a trigger copies the counts to the reloads.
// R6: with split set, the timer runs as two 8-bit auto-reload counters.
// R7: with split clear, the timer is one 16-bit auto-reload counter.
// R8: the high-byte flag sets when the high byte wraps; software clears it.
// R9: in split mode the run bit gates only the high byte.
// R10: each auto-reload loads the wrapping byte from its reload value.
`timescale 1ns/1ns
`include "tm3_cfg.svh"

module tm3_ctrl (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// register port
	input wire tm3_pkg::tm3_req_t bus_req_i,
	output logic [`TM3_DATA_W-1:0] rdata_o,
	// count sources and triggers
	input wire logic tick_low_i,
	input wire logic tick_high_i,
	input wire logic capture_trig_i,
	input wire logic timer_int_enable_i,
	// status towards the system
	output logic irq_o,
	output logic [1:0] clock_select_o,
	output logic low_roll_o,
	output logic high_roll_o
);

	function automatic logic reg_hit(
		input logic [`TM3_ADDR_W-1:0] addr,
		input logic [`TM3_ADDR_W-1:0] idx
	);
		reg_hit = (addr == idx);
	endfunction : reg_hit

	tm3_pkg::tm3_ctrl_t ctrl;
	tm3_pkg::tm3_ctrl_t next_ctrl;
	logic [7:0] reload [2];
	logic [7:0] next_reload [2];
	logic [7:0] count [2];
	logic [1:0] inc;
	logic [1:0] roll;
	logic [1:0] reload_en;
	logic [1:0] sw_load;
	logic [`TM3_DATA_W-1:0] next_rdata;
	logic next_irq;
	logic low_irq_src;
	logic next_low_roll;
	logic next_high_roll;
	logic [1:0] next_clock_select;

	// register decode
	wire logic wr_ctrl;
	wire logic wr_cnt_lo;
	wire logic wr_cnt_hi;
	wire logic wr_rld_lo;
	wire logic wr_rld_hi;
	wire logic capture;
	wire logic split;
	wire logic run;

	assign wr_ctrl = bus_req_i.wr & reg_hit(bus_req_i.addr, `TM3_IDX_CTRL);
	assign wr_cnt_lo = bus_req_i.wr
		& reg_hit(bus_req_i.addr, `TM3_IDX_CNT_LO);
	assign wr_cnt_hi = bus_req_i.wr
		& reg_hit(bus_req_i.addr, `TM3_IDX_CNT_HI);
	assign wr_rld_lo = bus_req_i.wr
		& reg_hit(bus_req_i.addr, `TM3_IDX_RLD_LO);
	assign wr_rld_hi = bus_req_i.wr
		& reg_hit(bus_req_i.addr, `TM3_IDX_RLD_HI);
	assign sw_load = {wr_cnt_hi, wr_cnt_lo};

	assign split = ctrl.split_mode_select;
	assign run = ctrl.timer_run_control;
	assign capture = capture_trig_i & ctrl.capture_mode_enable; // [R5]

	// low byte: free running in split mode, gated by run otherwise
	assign inc[0] = split ? tick_low_i : (run & tick_low_i); // [R9]
	// high byte: own tick in split mode, carry from low byte otherwise
	assign inc[1] = split ? (run & tick_high_i) : roll[0]; // [R6] [R7]

	// split mode reloads each byte on its own rollover; 16-bit mode
	// reloads both bytes only when the whole counter wraps
	assign reload_en[0] = split ? 1'b1 : roll[1]; // [R6] [R7] [R10]
	assign reload_en[1] = split | roll[0]; // [R10]

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_byte
			tm3_byte u_byte (
				.sys_clk_i(sys_clk_i),
				.nrst_i(nrst_i),
				.sw_load_i(sw_load[gi]),
				.sw_data_i(bus_req_i.wdata),
				.inc_i(inc[gi]),
				.reload_i(reload_en[gi]),
				.reload_val_i(reload[gi]),
				.count_o(count[gi]),
				.roll_o(roll[gi])
			);
		end
	endgenerate

	// control register: writes store every field, but a rollover in the
	// same cycle as a clearing write still leaves its flag set
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = tm3_pkg::tm3_ctrl_t'(bus_req_i.wdata); // [R2]
		end
		if (roll[0]) begin
			next_ctrl.low_byte_overflow_flag = 1'b1; // [R1]
		end
		if (roll[1] | capture) begin
			next_ctrl.high_byte_overflow_flag = 1'b1; // [R8]
		end
	end

	// reload registers: a capture overrides a software write
	// capture takes the counts from before this edge's increment
	always_comb begin
		next_reload[0] = reload[0];
		next_reload[1] = reload[1];
		if (wr_rld_lo) begin
			next_reload[0] = bus_req_i.wdata;
		end
		if (wr_rld_hi) begin
			next_reload[1] = bus_req_i.wdata;
		end
		if (capture) begin
			next_reload[0] = count[0]; // [R5]
			next_reload[1] = count[1]; // [R5]
		end
	end

	// interrupt request from the flags and their enables
	assign low_irq_src = next_ctrl.low_byte_overflow_flag
		& next_ctrl.low_byte_interrupt_enable; // [R3]
	assign next_irq = timer_int_enable_i
		& (next_ctrl.high_byte_overflow_flag | low_irq_src); // [R4]

	// status pulses: a wrap shows for one cycle after the edge that made it
	assign next_low_roll = roll[0]; // [R1]
	assign next_high_roll = roll[1]; // [R8]
	assign next_clock_select = next_ctrl.clock_select;

	// read data, valid only in the cycle after the read strobe
	always_comb begin
		next_rdata = `TM3_RD_UNMAPPED;
		if (bus_req_i.rd) begin
			unique case (bus_req_i.addr)
				`TM3_IDX_CTRL: begin
					next_rdata = ctrl;
				end
				`TM3_IDX_CNT_LO: begin
					next_rdata = count[0];
				end
				`TM3_IDX_CNT_HI: begin
					next_rdata = count[1];
				end
				`TM3_IDX_RLD_LO: begin
					next_rdata = reload[0];
				end
				`TM3_IDX_RLD_HI: begin
					next_rdata = reload[1];
				end
				default: begin
					next_rdata = `TM3_RD_UNMAPPED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl <= tm3_pkg::tm3_ctrl_t'(`TM3_CTRL_RST);
		end else begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reload[0] <= `TM3_BYTE_RST;
			reload[1] <= `TM3_BYTE_RST;
		end else begin
			reload[0] <= next_reload[0];
			reload[1] <= next_reload[1];
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= `TM3_RD_UNMAPPED;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
			clock_select_o <= 2'h0;
		end else begin
			irq_o <= next_irq;
			clock_select_o <= next_clock_select;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_roll_o <= 1'b0;
			high_roll_o <= 1'b0;
		end else begin
			low_roll_o <= next_low_roll;
			high_roll_o <= next_high_roll;
		end
	end

endmodule : tm3_ctrl

// ===== test/tm3_chk_assertions.sv
`timescale 1ns/1ns
module tm3_chk (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// watched ports
	input wire tm3_pkg::tm3_req_t bus_req_i,
	input wire logic [7:0] rdata_o,
	input wire logic tick_low_i,
	input wire logic tick_high_i,
	input wire logic timer_int_enable_i,
	input wire logic irq_o,
	input wire logic [1:0] clock_select_o,
	input wire logic low_roll_o,
	input wire logic high_roll_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	AST_IRQ_EN: assert property (irq_o |-> $past(timer_int_enable_i))
		else $error("irq without general enable");
	AST_IRQ_HOLD: assert property ((irq_o && timer_int_enable_i &&
		!bus_req_i.wr) |=> irq_o)
		else $error("irq dropped without a write");
	AST_LO_ROLL: assert property (low_roll_o |-> $past(tick_low_i))
		else $error("low roll without tick");
	AST_HI_ROLL: assert property (high_roll_o |->
		$past(tick_low_i) || $past(tick_high_i))
		else $error("high roll without tick");
	AST_HI_CARRY: assert property (high_roll_o && !$past(tick_high_i)
		|-> low_roll_o)
		else $error("wide wrap without low roll");
	AST_RD_IDLE: assert property (!$past(bus_req_i.rd) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_CK_HOLD: assert property (!$past(bus_req_i.wr) |->
		$stable(clock_select_o))
		else $error("clock select moved");
	AST_CK_WR: assert property (bus_req_i.wr && bus_req_i.addr == 3'h0 |=>
		clock_select_o == $past(bus_req_i.wdata[1:0]))
		else $error("clock select not written");
endmodule : tm3_chk

bind tm3_ctrl tm3_chk u_chk (.sys_clk_i, .nrst_i, .bus_req_i, .rdata_o,
	.tick_low_i, .tick_high_i, .timer_int_enable_i, .irq_o, .clock_select_o,
	.low_roll_o, .high_roll_o);

// ===== test/tm3_ctrl_bench.sv
`timescale 1ns/1ns
module tm3_ctrl_bench;
	logic sys_clk_i = 0;
	logic nrst_i = 0;
	tm3_pkg::tm3_req_t req = '0;
	logic tl = 0, th = 0, trig = 0, gen = 0;
	logic [7:0] rdata;
	logic irq;
	logic [1:0] cks;
	logic lrl, hrl;
	int m[5];
	int err_total = 0;
	int checked = 0;
	integer seed = 23013;
	int cyc = 0;
	tm3_ctrl u_tm3_ctrl (.sys_clk_i, .nrst_i, .bus_req_i(req), .rdata_o(rdata),
		.tick_low_i(tl), .tick_high_i(th), .capture_trig_i(trig),
		.timer_int_enable_i(gen), .irq_o(irq), .clock_select_o(cks),
		.low_roll_o(lrl), .high_roll_o(hrl));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			finish_test();
		end
	end
	task finish_test();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task chk(string n, int e, logic [7:0] g);
		checked++;
		if (g !== 8'(e)) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, 8'(e), g);
		end
	endtask : chk
	function int roll(int i, int r, int f);
		if (m[i] != 255)
			return m[i] + 1;
		m[0] |= f;
		return m[r];
	endfunction : roll
	task wr(int a, int d);
		@(posedge sys_clk_i);
		req <= {3'(a), 8'(d), 1'b1, 1'b0};
		@(posedge sys_clk_i);
		req <= '0;
		m[a] = d & 255;
	endtask : wr
	task tick(bit l, bit h, bit c);
		int lr, hr, ei;
		@(posedge sys_clk_i);
		{tl, th, trig} <= {l, h, c};
		@(posedge sys_clk_i);
		{tl, th, trig} <= 3'h0;
		lr = l && m[1] == 255 && (m[0][3] || m[0][2]);
		hr = m[2] == 255 && (m[0][3] ? (h && m[0][2]) : lr);
		if (c && m[0][4]) begin
			m[3] = m[1];
			m[4] = m[2];
			m[0] |= 128;
		end
		if (m[0][3]) begin
			if (l) m[1] = roll(1, 3, 64);
			if (h && m[0][2]) m[2] = roll(2, 4, 128);
		end else if (l && m[0][2]) begin
			if (m[1] == 255 && m[2] != 255) begin
				m[2]++;
				m[1] = 0;
				m[0] |= 64;
			end else begin
				if (m[1] == 255) m[2] = roll(2, 4, 128);
				m[1] = roll(1, 3, 64);
			end
		end
		ei = gen & (m[0][7] | m[0][6] & m[0][5]);
		#1 chk("irq", ei, 8'(irq));
		chk("low roll", lr, 8'(lrl));
		chk("high roll", hr, 8'(hrl));
	endtask : tick
	task cmp_all();
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk_i);
			req <= {3'(i), 8'h00, 1'b0, 1'b1};
			@(posedge sys_clk_i);
			req <= '0;
			#1 chk($sformatf("reg%0d", i), i < 5 ? m[i] : 0, rdata);
		end
		chk("clock select", m[0] & 3, 8'(cks));
	endtask : cmp_all
	initial begin
		repeat (5) @(posedge sys_clk_i);
		nrst_i <= 1;
		cmp_all();
		for (int e = 0; e < 4; e++) begin
			@(posedge sys_clk_i);
			gen <= e[1];
			wr(0, 8 | e[0] << 5 | e);
			wr(3, $random(seed));
			wr(1, 255);
			tick(1, 0, 0);
			tick(1, 0, 0);
			cmp_all();
		end
		$display("split flag test done");
		wr(0, 4);
		wr(4, $random(seed));
		wr(2, 255);
		wr(1, 255);
		tick(1, 0, 0);
		wr(2, 18);
		wr(1, 255);
		tick(1, 0, 0);
		cmp_all();
		$display("wide mode test done");
		wr(0, 8);
		wr(2, 7);
		tick(1, 1, 0);
		wr(0, 12);
		tick(1, 1, 0);
		cmp_all();
		$display("run gate test done");
		wr(0, 16);
		tick(0, 0, 1);
		wr(0, 0);
		tick(0, 0, 1);
		cmp_all();
		$display("capture test done");
		finish_test();
	end
endmodule : tm3_ctrl_bench
